// file: logic/asram_consts.vh
// timing and width constants for the asynchronous sram port controller
`ifndef ASRAM_CONSTS_VH
`define ASRAM_CONSTS_VH
`define ASRAM_CLK_PERIOD_PS 5000
`define ASRAM_ADDR_W 16
`define ASRAM_DATA_W 4
// slowest grade figures, in ps
`define ASRAM_CYCLE_PS 25000
`define ASRAM_SELECT_TO_DATA_PS 25000
`define ASRAM_DRIVE_ENABLE_TO_DATA_PS 9000
`define ASRAM_TURN_OFF_PS 9000
`define ASRAM_WRITE_PULSE_MINIMUM_PS 15000
`define ASRAM_DATA_SETUP_TO_END_PS 10000
`define ASRAM_OUTPUT_ACTIVE_PS 4000
// cycle counts: least times round up, at least one
`define ASRAM_CEIL(ps) (((ps) + `ASRAM_CLK_PERIOD_PS - 1) / `ASRAM_CLK_PERIOD_PS)
`define ASRAM_CNT_W 4
`define ASRAM_CNT_ZERO 4'h0
`define ASRAM_CNT_ONE 4'h1
// idle and active levels of the low-active memory strobes
`define ASRAM_PIN_OFF 1'b1
`define ASRAM_PIN_ON 1'b0
`endif

// file: logic/asram_ctrl.v
// host-side controller sequencing a 64k x 4 asynchronous static memory
`timescale 1ns/100ps
`include "asram_consts.vh"
module asram_ctrl #(
  parameter ADDR_W = `ASRAM_ADDR_W,
  parameter DATA_W = `ASRAM_DATA_W
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // user request port
  input wire req_valid,
  input wire req_write,
  input wire [ADDR_W-1:0] req_addr,
  input wire [DATA_W-1:0] req_wdata,
  output reg req_ready,
  output reg rsp_valid,
  output reg [DATA_W-1:0] rsp_rdata,
  // memory pins
  output reg [ADDR_W-1:0] mem_addr,
  output reg mem_select_n,
  output reg mem_drive_enable_n,
  output reg mem_write_strobe_n,
  input wire [DATA_W-1:0] mem_data_in,
  output reg [DATA_W-1:0] mem_data_out,
  output reg mem_data_oe
);

  // cycle counts, rounded up from the slowest grade figures
  localparam integer RD_CYC_I = `ASRAM_CEIL(`ASRAM_SELECT_TO_DATA_PS);
  localparam integer OFF_CYC_I = `ASRAM_CEIL(`ASRAM_TURN_OFF_PS);
  localparam integer WP_CYC_I = `ASRAM_CEIL(`ASRAM_WRITE_PULSE_MINIMUM_PS);
  localparam integer DW_CYC_I = `ASRAM_CEIL(`ASRAM_DATA_SETUP_TO_END_PS);
  localparam integer REC_CYC_I = `ASRAM_CEIL(`ASRAM_OUTPUT_ACTIVE_PS);
  localparam integer CYC_CYC_I = `ASRAM_CEIL(`ASRAM_CYCLE_PS);
  // counts cut to the counter width on purpose
  localparam [`ASRAM_CNT_W-1:0] RD_CYC = RD_CYC_I[`ASRAM_CNT_W-1:0];
  localparam [`ASRAM_CNT_W-1:0] OFF_CYC = OFF_CYC_I[`ASRAM_CNT_W-1:0];
  localparam [`ASRAM_CNT_W-1:0] WP_CYC = WP_CYC_I[`ASRAM_CNT_W-1:0];
  localparam [`ASRAM_CNT_W-1:0] DW_CYC = DW_CYC_I[`ASRAM_CNT_W-1:0];
  localparam [`ASRAM_CNT_W-1:0] REC_CYC = REC_CYC_I[`ASRAM_CNT_W-1:0];
  localparam [`ASRAM_CNT_W-1:0] CYC_CYC = CYC_CYC_I[`ASRAM_CNT_W-1:0];

  // one-hot sequencer states
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_READ = 5'h02;
  localparam [4:0] S_WOFF = 5'h04;
  localparam [4:0] S_WRITE = 5'h08;
  localparam [4:0] S_REC = 5'h10;

  // sequencer state and counters
  reg [4:0] state_reg;
  reg [`ASRAM_CNT_W-1:0] cnt_reg;
  reg [`ASRAM_CNT_W-1:0] span_reg;
  wire [`ASRAM_CNT_W-1:0] wr_cyc;
  wire take;

  // pulse length: write-strobe and data setup both honoured
  function [`ASRAM_CNT_W-1:0] asram_max;
    input [`ASRAM_CNT_W-1:0] a;
    input [`ASRAM_CNT_W-1:0] b;
    begin
      asram_max = (a > b) ? a : b;
    end
  endfunction

  // countdown is in its final cycle
  function asram_last;
    input [`ASRAM_CNT_W-1:0] count;
    begin
      asram_last = (count <= `ASRAM_CNT_ONE);
    end
  endfunction

  // countdown by one, resting at zero
  function [`ASRAM_CNT_W-1:0] asram_dec;
    input [`ASRAM_CNT_W-1:0] count;
    begin
      if (count == `ASRAM_CNT_ZERO)
        asram_dec = `ASRAM_CNT_ZERO;
      else
        asram_dec = count - `ASRAM_CNT_ONE;
    end
  endfunction

  assign wr_cyc = asram_max(WP_CYC, DW_CYC);
  // a request is accepted only in idle with ready shown
  assign take = (state_reg == S_IDLE) && req_valid && req_ready;

  // spacing between the starts of two memory cycles
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      span_reg <= `ASRAM_CNT_ZERO;
    else if (take)
      span_reg <= CYC_CYC;
    else
      span_reg <= asram_dec(span_reg);
  end

  // pin sequencer
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= S_IDLE;
      cnt_reg <= `ASRAM_CNT_ZERO;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= {DATA_W{1'b0}};
      mem_addr <= {ADDR_W{1'b0}};
      mem_select_n <= `ASRAM_PIN_OFF;
      mem_drive_enable_n <= `ASRAM_PIN_OFF;
      mem_write_strobe_n <= `ASRAM_PIN_OFF;
      mem_data_out <= {DATA_W{1'b0}};
      mem_data_oe <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      case (state_reg)
        S_IDLE:
        begin
          req_ready <= asram_last(span_reg);
          if (take)
          begin
            req_ready <= 1'b0;
            // address moves only while select and strobe are high
            mem_addr <= req_addr;
            mem_select_n <= `ASRAM_PIN_ON;
            if (req_write)
            begin
              // select falls first; outputs stay disabled
              mem_drive_enable_n <= `ASRAM_PIN_OFF;
              mem_data_out <= req_wdata;
              cnt_reg <= OFF_CYC;
              state_reg <= S_WOFF;
            end
            else
            begin
              mem_drive_enable_n <= `ASRAM_PIN_ON;
              mem_write_strobe_n <= `ASRAM_PIN_OFF;
              cnt_reg <= RD_CYC;
              state_reg <= S_READ;
            end
          end
        end
        S_READ:
        begin
          // data taken at the end of the select access time
          if (asram_last(cnt_reg))
          begin
            rsp_rdata <= mem_data_in;
            rsp_valid <= 1'b1;
            mem_select_n <= `ASRAM_PIN_OFF;
            mem_drive_enable_n <= `ASRAM_PIN_OFF;
            cnt_reg <= OFF_CYC;
            state_reg <= S_REC;
          end
          else
            cnt_reg <= asram_dec(cnt_reg);
        end
        S_WOFF:
        begin
          // wait out memory turn-off before driving the data bus
          if (asram_last(cnt_reg))
          begin
            mem_write_strobe_n <= `ASRAM_PIN_ON;
            mem_data_oe <= 1'b1;
            cnt_reg <= wr_cyc;
            state_reg <= S_WRITE;
          end
          else
            cnt_reg <= asram_dec(cnt_reg);
        end
        S_WRITE:
        begin
          if (asram_last(cnt_reg))
          begin
            // strobe rises ends the write; data held one more cycle
            mem_write_strobe_n <= `ASRAM_PIN_OFF;
            cnt_reg <= REC_CYC;
            state_reg <= S_REC;
          end
          else
            cnt_reg <= asram_dec(cnt_reg);
        end
        S_REC:
        begin
          // bus released and select high before the next cycle
          mem_data_oe <= 1'b0;
          mem_select_n <= `ASRAM_PIN_OFF;
          if (asram_last(cnt_reg))
            state_reg <= S_IDLE;
          else
            cnt_reg <= asram_dec(cnt_reg);
        end
        default:
        begin
          cnt_reg <= `ASRAM_CNT_ZERO;
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule // asram_ctrl

// file: verif/asram_monitor.sv
// checker of the sram port controller pins
`timescale 1ns/100ps
module asram_monitor(
  // design ports
  input wire clk, resetn, req_valid, req_write, req_ready, rsp_valid,
  input wire mem_select_n, mem_drive_enable_n, mem_write_strobe_n, mem_data_oe,
  input wire [15:0] req_addr, mem_addr,
  input wire [3:0] req_wdata, rsp_rdata, mem_data_in, mem_data_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_addr_hold: assert property (!mem_write_strobe_n |-> $stable(mem_addr))
    else $error("addr moved in write");
  a_read_strobe: assert property (!mem_drive_enable_n |-> mem_write_strobe_n)
    else $error("strobe low in read");
  a_no_fight: assert property (mem_data_oe |-> mem_drive_enable_n)
    else $error("data contention");
  a_pulse_len: assert property ($fell(mem_write_strobe_n) |->
    (!mem_write_strobe_n)[*3] ##1 mem_write_strobe_n) else $error("strobe width");
  a_select_end: assert property ($rose(mem_write_strobe_n) |->
    !mem_select_n && !$past(mem_select_n, 3)) else $error("select width");
  a_data_setup: assert property (!mem_write_strobe_n |->
    mem_data_oe && $stable(mem_data_out)) else $error("write data");
  a_read_answer: assert property (req_valid && req_ready && !req_write |->
    ##[6:7] rsp_valid) else $error("read answer");
  a_cycle_space: assert property (req_valid && req_ready |->
    ##2 (!req_ready)[*4]) else $error("cycle spacing");
  cover property (req_valid && req_ready && req_write);
  cover property (rsp_valid);
  cover property ($rose(mem_write_strobe_n));
endmodule // asram_monitor

// file: verif/asram_mem_model.sv
// behavioural model of the 64k x 4 static memory
`timescale 1ns/100ps
module asram_mem_model(
  // memory pins
  input wire mem_select_n, mem_drive_enable_n, mem_write_strobe_n,
  input wire [15:0] mem_addr,
  input wire [3:0] mem_data_out,
  output reg [3:0] mem_data_in
);
  reg [3:0] cells [0:65535];
  reg [3:0] last_reg = 4'h5;
  wire reading = !mem_select_n && !mem_drive_enable_n && mem_write_strobe_n;
  always @(posedge mem_write_strobe_n)
    if (!mem_select_n) cells[mem_addr] = mem_data_out;
  // each change: old data held briefly, then the last read data inverted, then new data while reading
  always @(reading or mem_addr)
  begin
    mem_data_in <= #3 ~last_reg;
    if (reading)
    begin
      mem_data_in <= #20 cells[mem_addr];
      last_reg <= #20 cells[mem_addr];
    end
  end
endmodule // asram_mem_model

// file: verif/testbench.sv
// self-checking bench for the sram port controller
`timescale 1ns/100ps
module testbench;
  reg clk = 0, resetn = 0, req_valid = 0, req_write = 0;
  reg [15:0] req_addr = 16'h0;
  reg [3:0] req_wdata = 4'h0;
  wire req_ready, rsp_valid, mem_select_n, mem_drive_enable_n, mem_write_strobe_n, mem_data_oe;
  wire [3:0] rsp_rdata, mem_data_in, mem_data_out;
  wire [15:0] mem_addr;
  reg [15:0] a [0:7];
  reg [3:0] d [0:7];
  reg [3:0] q [$];
  integer seed = 57108, errors = 0, samples_checked = 0, i;
  always #2.5 clk = ~clk;
  asram_ctrl dut(
    .clk(clk), .resetn(resetn), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_addr(mem_addr),
    .mem_select_n(mem_select_n), .mem_drive_enable_n(mem_drive_enable_n),
    .mem_write_strobe_n(mem_write_strobe_n), .mem_data_in(mem_data_in),
    .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe)
  );
  asram_mem_model mem(
    .mem_select_n(mem_select_n), .mem_drive_enable_n(mem_drive_enable_n),
    .mem_write_strobe_n(mem_write_strobe_n), .mem_addr(mem_addr),
    .mem_data_out(mem_data_out), .mem_data_in(mem_data_in)
  );
  task chk(input string n, input [3:0] e, input [3:0] g);
  begin
    samples_checked = samples_checked + 1;
    if (g !== e) begin errors = errors + 1; $display("Error %s expected %h seen %h", n, e, g); end
  end
  endtask
  task xfer(input w, input [15:0] ad, input [3:0] dt);
  begin
    @(negedge clk);
    req_valid = 1; req_write = w; req_addr = ad; req_wdata = w ? dt : $random(seed);
    while (req_ready !== 1'b1) @(negedge clk);
    if (!w) q.push_back(dt);
    @(negedge clk);
    req_valid = 0;
  end
  endtask
  task close_out;
  begin
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  end
  endtask
  always @(negedge clk) if (rsp_valid === 1'b1) chk("rdata", q.pop_front(), rsp_rdata);
  initial begin #10000; errors = errors + 1; close_out; end
  initial
  begin
    repeat (4) @(negedge clk);
    resetn = 1;
    for (i = 0; i < 8; i = i + 1)
    begin
      a[i] = $random(seed);
      a[i][2:0] = i; // distinct words, so no read is shadowed
      if (i == 0) a[i] = 16'h0000;
      if (i == 7) a[i] = 16'hffff;
      d[i] = $random(seed);
      xfer(1, a[i], d[i]);
    end
    d[7] = ~d[7];
    xfer(1, a[7], d[7]);
    $display("test writes done");
    for (i = 7; i >= 0; i = i - 1) xfer(0, a[i], d[i]);
    repeat (12) @(negedge clk);
    chk("pending", 4'h0, 4'(q.size()));
    $display("test reads done");
    close_out;
  end
endmodule // testbench
bind asram_ctrl asram_monitor mon(
  .clk(clk), .resetn(resetn), .req_valid(req_valid), .req_write(req_write),
  .req_ready(req_ready), .rsp_valid(rsp_valid), .mem_select_n(mem_select_n),
  .mem_drive_enable_n(mem_drive_enable_n), .mem_write_strobe_n(mem_write_strobe_n),
  .mem_data_oe(mem_data_oe), .req_addr(req_addr), .mem_addr(mem_addr),
  .req_wdata(req_wdata), .rsp_rdata(rsp_rdata), .mem_data_in(mem_data_in),
  .mem_data_out(mem_data_out)
);
